// ### seq_io_pkg.sv
// Purpose: Shared constants and types of the sequencer TTL I/O port
// Assumes: 100 MHz clock, 32-bit AHB-Lite register access
// Notes: Command word is op[15:12], arg[11:0]
package seq_io_pkg;
  // Clock and pulse timing
  localparam int CLK_NS = 10;
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  // Storage shape
  localparam int NSLOT = 6;
  localparam int SLOT_BYTES = 2048;
  localparam int CMD_BYTES = 2;
  localparam int SLOT_WORDS = SLOT_BYTES / CMD_BYTES;
  localparam int STACK_DEPTH = 4;
  localparam int NIN = 5;
  localparam int NOUT = 8;
  localparam logic [2:0] AUTO_SLOT = 3'h5;
  localparam logic [2:0] MAX_IN_IDX = 3'h4;
  localparam logic [9:0] LAST_PC = 10'h3ff;
  localparam logic [31:0] AUTO_TITLE = 32'h4155544f;
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LOAD_ADDR = 8'h08;
  localparam logic [7:0] OFS_LOAD_DATA = 8'h0c;
  localparam logic [7:0] OFS_TITLE = 8'h10;
  localparam logic [7:0] OFS_LOOP_TITLE = 8'h14;
  localparam logic [7:0] OFS_LOOP_CNT = 8'h18;
  // Control fields
  localparam int CTRL_GPIO = 0;
  localparam int CTRL_STEPM = 1;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_STEP = 3;
  localparam int CTRL_ABORT = 4;
  localparam int CTRL_SLOT_LSB = 5;
  localparam int CTRL_CLR = 8;
  localparam int LOAD_SLOT_LSB = 10;
  // Reset values
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic TTL_RST = 1'b1;
  // Operation codes passed to the measurement engine
  localparam logic [11:0] OPC_AUTOSCALE = 12'h001;
  localparam logic [11:0] OPC_DATA_MEM = 12'h002;

  typedef enum logic [3:0] {
    OP_END = 4'h0, OP_OUT_ALL = 4'h1, OP_SET_BIT = 4'h2, OP_CLR_BIT = 4'h3,
    OP_SEL_IN = 4'h4, OP_BR_HIGH = 4'h5, OP_BR_LOW = 4'h6, OP_JUMP = 4'h7,
    OP_GOSUB = 4'h8, OP_SWEEP = 4'h9, OP_DISRUPT = 4'ha, OP_OP = 4'hb,
    OP_TTL_MODE = 4'hc, OP_LOOP_SET = 4'hd, OP_LOOP_TITLE = 4'he,
    OP_LOOP_DEC = 4'hf
  } op_e;

  typedef enum logic [1:0] {
    TTL_HIGH = 2'h0, TTL_LOW = 2'h1, TTL_HPULSE = 2'h2, TTL_LPULSE = 2'h3
  } ttl_mode_e;

  typedef struct packed {
    op_e op;
    logic [11:0] arg;
  } cmd_s;

  typedef struct packed {
    logic [2:0] slot;
    logic [9:0] pc;
  } loc_s;
endpackage

// ### in_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk
// Notes: First stage read only by second stage
`timescale 1ns/10ps
module in_sync #(parameter int W = 6)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins and synced copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // in_sync

// ### rear_ttl_gen.sv
// Purpose: Rear TTL output level and sweep-end pulse generator
// Assumes: sweep_end is a one-cycle pulse on clk
// Notes: Pulse lasts PULSE_CYC cycles from the cycle after sweep_end
`timescale 1ns/10ps
module rear_ttl_gen import seq_io_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire ttl_mode_e mode,
  input wire logic sweep_end,
  // Output
  output logic ttl_out
);
  localparam int CW = $clog2(PULSE_CYC + 1);
  logic [CW-1:0] cnt;
  logic active;

  assign active = sweep_end || (cnt > CW'(1));

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= '0;
    else if (sweep_end)
      cnt <= CW'(PULSE_CYC);
    else if (cnt != '0)
      cnt <= cnt - CW'(1);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ttl_out <= TTL_RST;
    else
    begin
      unique case (mode)
        TTL_HIGH: ttl_out <= 1'b1;
        TTL_LOW: ttl_out <= 1'b0;
        TTL_HPULSE: ttl_out <= active;
        TTL_LPULSE: ttl_out <= !active;
      endcase
    end
  end
endmodule // rear_ttl_gen

// ### seq_ttl_io.sv
// Purpose: Sequence engine with TTL parallel I/O and rear TTL output
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: Six stored sequences of 1024 command words each
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
module seq_ttl_io import seq_io_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Parallel port pins
  input wire logic [NIN-1:0] par_in,
  output logic [NOUT-1:0] par_out,
  output logic par_out_en,
  input wire logic local_key,
  // Rear TTL output
  output logic rear_ttl,
  // Measurement engine
  input wire logic sweep_end,
  output logic sweep_req,
  output logic op_req,
  output logic [11:0] op_code,
  input wire logic op_done
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_FETCH = 5'b00010, ST_EXEC = 5'b00100,
    ST_WAIT_OP = 5'b01000, ST_WAIT_SWEEP = 5'b10000
  } state_e;

  state_e state;
  loc_s cur;
  loc_s stk [0:STACK_DEPTH-1];
  logic [2:0] sp;
  logic [15:0] mem [0:NSLOT*SLOT_WORDS-1];
  logic [31:0] title [0:NSLOT-1];
  logic [NSLOT-1:0] slot_valid;
  logic [15:0] mem_q;
  cmd_s cmd;
  logic boot, gpio_mode, step_mode, step_pend, inhibit, load_err, load_full;
  logic [2:0] start_slot, load_slot, sel;
  logic [9:0] load_pc;
  logic [NOUT-1:0] out_lines;
  ttl_mode_e ttl_mode;
  logic [15:0] loop_cnt;
  logic [19:0] loop_bcd;
  logic [NIN:0] pins_q;
  logic [NIN-1:0] in_q;
  logic key_q, key_prev, key_press;
  logic wr_pend, ahb_go, exec, at_end, blocked, in_bit;
  logic [7:0] wr_addr;
  logic [31:0] rd_val;
  logic wr_ctrl, run_go, step_go, abort_go;
  logic [1:0] top_idx;

  function automatic logic slot_ok(input logic [2:0] s,
                                   input logic [NSLOT-1:0] v);
    return (s < 3'(NSLOT)) ? v[s] : 1'b0;
  endfunction

  function automatic logic [19:0] to_bcd(input logic [15:0] b);
    logic [35:0] t;
    t = {20'h00000, b};
    for (int i = 0; i < 16; i++)
    begin
      for (int d = 0; d < 5; d++)
        if (t[16+4*d +: 4] > 4'h4)
          t[16+4*d +: 4] = t[16+4*d +: 4] + 4'h3;
      t = {t[34:0], 1'b0};
    end
    return t[35:16];
  endfunction

  // Input pins through two flops
  in_sync #(.W(NIN + 1)) u_sync
  (
    .clk(clk),
    .rstn(rstn),
    .d({local_key, par_in}),
    .q(pins_q)
  );

  rear_ttl_gen u_rear
  (
    .clk(clk),
    .rstn(rstn),
    .mode(ttl_mode),
    .sweep_end(sweep_end),
    .ttl_out(rear_ttl)
  );

  assign in_q = pins_q[NIN-1:0];
  assign key_q = pins_q[NIN];
  assign key_press = key_q && !key_prev;
  assign cmd = cmd_s'(mem_q);
  assign exec = (state == ST_EXEC);
  assign at_end = (cur.pc == LAST_PC);
  assign top_idx = 2'(sp - 3'h1);
  // relies on level present before sampling
  assign in_bit = in_q[sel];

  // Bus slave
  assign ahb_go = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_ctrl = wr_pend && (wr_addr == OFS_CTRL);
  assign run_go = wr_ctrl && hwdata[CTRL_RUN];
  assign step_go = wr_ctrl && hwdata[CTRL_STEP];
  assign abort_go = wr_ctrl && hwdata[CTRL_ABORT];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend <= ahb_go && hwrite;
      if (ahb_go)
        wr_addr <= haddr[7:0];
      if (ahb_go && !hwrite)
        hrdata <= rd_val;
    end
  end

  always_comb
  begin
    rd_val = 32'h00000000;
    unique case (haddr[7:0])
      OFS_CTRL: rd_val = {23'h000000, 1'b0, start_slot, 3'h0,
                          step_mode, gpio_mode};
      OFS_STATUS: rd_val = {5'h00, sp, sel, in_q, out_lines, ttl_mode,
                            cur.slot, load_err, inhibit,
                            state != ST_IDLE};
      OFS_LOAD_ADDR: rd_val = {19'h00000, load_slot, load_pc};
      OFS_LOOP_TITLE: rd_val = {12'h000, loop_bcd};
      OFS_LOOP_CNT: rd_val = {16'h0000, loop_cnt};
      default: rd_val = 32'h00000000;
    endcase
  end

  // Control register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gpio_mode <= 1'b0;
      step_mode <= 1'b0;
      start_slot <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      gpio_mode <= hwdata[CTRL_GPIO];
      step_mode <= hwdata[CTRL_STEPM];
      start_slot <= hwdata[CTRL_SLOT_LSB +: 3];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      load_slot <= 3'h0;
      load_pc <= 10'h000;
      load_full <= 1'b0;
      load_err <= 1'b0;
    end
    else if (wr_pend && wr_addr == OFS_LOAD_ADDR)
    begin
      load_slot <= hwdata[LOAD_SLOT_LSB +: 3];
      load_pc <= hwdata[9:0];
      load_full <= 1'b0;
      load_err <= 1'b0;
    end
    else if (wr_pend && wr_addr == OFS_LOAD_DATA)
    begin
      if (load_full || load_slot >= 3'(NSLOT))
        load_err <= 1'b1;
      else
      begin
        load_pc <= load_pc + 10'h001;
        load_full <= (load_pc == LAST_PC);
      end
    end
  end

  // Retained sequence storage
  always_ff @(posedge clk)
  begin
    if (wr_pend && wr_addr == OFS_LOAD_DATA && !load_full &&
        load_slot < 3'(NSLOT))
    begin
      mem[{load_slot, load_pc}] <= hwdata[15:0];
      slot_valid[load_slot] <= 1'b1;
    end
    else if (wr_ctrl && hwdata[CTRL_CLR])
      slot_valid <= '0;
    if (wr_pend && wr_addr == OFS_TITLE && load_slot < 3'(NSLOT))
      title[load_slot] <= hwdata;
    mem_q <= mem[{cur.slot, cur.pc}];
  end

  // Step request and key edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      step_pend <= 1'b0;
      key_prev <= 1'b0;
    end
    else
    begin
      key_prev <= key_q;
      step_pend <= step_go ||
                   (step_pend && !(state == ST_FETCH && step_mode));
    end
  end

  // Sequence engine
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= ST_IDLE;
      cur <= '0;
      sp <= 3'h0;
      boot <= 1'b1;
    end
    else
    begin
      boot <= 1'b0;
      if (abort_go || key_press)
      begin
        state <= ST_IDLE;
        sp <= 3'h0;
      end
      else
      begin
        unique case (state)
          ST_IDLE:
          begin
            if (boot && title[AUTO_SLOT] == AUTO_TITLE &&
                slot_ok(AUTO_SLOT, slot_valid))
            begin
              cur <= '{slot: AUTO_SLOT, pc: 10'h000};
              state <= ST_FETCH;
            end
            else if (run_go && slot_ok(start_slot, slot_valid))
            begin
              cur <= '{slot: start_slot, pc: 10'h000};
              state <= ST_FETCH;
            end
          end
          ST_FETCH:
          begin
            if (!step_mode || step_pend)
              state <= ST_EXEC;
          end
          ST_EXEC:
          begin
            state <= ST_FETCH;
            if (at_end || cmd.op == OP_END)
            begin
              if (sp != 3'h0)
              begin
                cur <= stk[top_idx];
                sp <= sp - 3'h1;
              end
              else
                state <= ST_IDLE;
            end
            else
              cur.pc <= cur.pc + 10'h001;
            unique case (cmd.op)
              OP_BR_HIGH, OP_BR_LOW, OP_JUMP:
              begin
                if (cmd.op == OP_JUMP ||
                    (gpio_mode && (in_bit == (cmd.op == OP_BR_HIGH))))
                begin
                  cur <= '{slot: cmd.arg[2:0], pc: 10'h000};
                  state <= slot_ok(cmd.arg[2:0], slot_valid) ?
                           ST_FETCH : ST_IDLE;
                end
              end
              OP_GOSUB:
              begin
                if (slot_ok(cmd.arg[2:0], slot_valid) &&
                    sp < 3'(STACK_DEPTH))
                begin
                  stk[sp[1:0]] <= '{slot: cur.slot, pc: cur.pc + 10'h001};
                  sp <= sp + 3'h1;
                  cur <= '{slot: cmd.arg[2:0], pc: 10'h000};
                  state <= ST_FETCH;
                end
                else
                  state <= ST_IDLE;
              end
              OP_SWEEP: state <= ST_WAIT_SWEEP;
              OP_DISRUPT: state <= ST_WAIT_OP;
              OP_OP: if (!blocked) state <= ST_WAIT_OP;
              default: ;
            endcase
          end
          ST_WAIT_OP: if (op_done) state <= ST_FETCH;
          ST_WAIT_SWEEP: if (sweep_end) state <= ST_FETCH;
        endcase
      end
    end
  end

  assign blocked = inhibit &&
                   (cmd.arg == OPC_AUTOSCALE || cmd.arg == OPC_DATA_MEM);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      inhibit <= 1'b0;
    else if (exec && cmd.op == OP_DISRUPT)
      inhibit <= 1'b1;
    else if (sweep_end)
      inhibit <= 1'b0;
  end

  assign op_req = exec && (cmd.op == OP_DISRUPT ||
                           (cmd.op == OP_OP && !blocked));
  assign sweep_req = exec && (cmd.op == OP_SWEEP);
  assign op_code = cmd.arg;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      par_out_en <= 1'b0;
    else
      par_out_en <= gpio_mode;
  end
  assign par_out = out_lines;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_lines <= OUT_RST;
      sel <= SEL_RST;
    end
    else if (exec && gpio_mode)
    begin
      unique case (cmd.op)
        OP_OUT_ALL: out_lines <= cmd.arg[7:0];
        OP_SET_BIT: out_lines[cmd.arg[2:0]] <= 1'b1;
        OP_CLR_BIT: out_lines[cmd.arg[2:0]] <= 1'b0;
        OP_SEL_IN: if (cmd.arg[2:0] <= MAX_IN_IDX) sel <= cmd.arg[2:0];
        default: ;
      endcase
    end
  end

  // Rear mode and loop counter
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ttl_mode <= TTL_HIGH;
      loop_cnt <= 16'h0000;
      loop_bcd <= 20'h00000;
    end
    else if (exec)
    begin
      if (cmd.op == OP_TTL_MODE)
        ttl_mode <= ttl_mode_e'(cmd.arg[1:0]);
      if (cmd.op == OP_LOOP_SET)
        loop_cnt <= {4'h0, cmd.arg};
      if (cmd.op == OP_LOOP_DEC)
        loop_cnt <= loop_cnt - 16'h0001;
      if (cmd.op == OP_LOOP_TITLE)
        loop_bcd <= to_bcd(loop_cnt);
    end
  end

  copy_mode_a: assert property (@(posedge clk) disable iff (!rstn)
    !$past(gpio_mode) |-> !par_out_en) else $error("out enabled in copy");
  out_all_a: assert property (@(posedge clk) disable iff (!rstn)
    exec && gpio_mode && cmd.op == OP_OUT_ALL |=>
    par_out == $past(cmd.arg[7:0])) else $error("byte not driven");
  set_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    exec && gpio_mode && cmd.op == OP_SET_BIT |=>
    par_out == ($past(out_lines) | (8'h01 << $past(cmd.arg[2:0]))))
    else $error("set bit wrong");
  clr_bit_a: assert property (@(posedge clk) disable iff (!rstn)
    exec && gpio_mode && cmd.op == OP_CLR_BIT |=>
    par_out == ($past(out_lines) & ~(8'h01 << $past(cmd.arg[2:0]))))
    else $error("clear bit wrong");
  sel_range_a: assert property (@(posedge clk) disable iff (!rstn)
    sel <= MAX_IN_IDX) else $error("selector out of range");
  br_high_a: assert property (@(posedge clk) disable iff (!rstn)
    exec && gpio_mode && cmd.op == OP_BR_HIGH && in_bit && !at_end &&
    slot_ok(cmd.arg[2:0], slot_valid) && !abort_go && !key_press |=>
    state == ST_FETCH && cur.pc == 10'h000 &&
    cur.slot == $past(cmd.arg[2:0])) else $error("high branch");
  br_low_a: assert property (@(posedge clk) disable iff (!rstn)
    exec && gpio_mode && cmd.op == OP_BR_LOW && in_bit && !at_end &&
    !abort_go && !key_press |=>
    cur.pc == $past(cur.pc) + 10'h001) else $error("low branch");
  gosub_a: assert property (@(posedge clk) disable iff (!rstn)
    exec && cmd.op == OP_GOSUB && sp < 3'(STACK_DEPTH) &&
    slot_ok(cmd.arg[2:0], slot_valid) && !abort_go && !key_press |=>
    sp == $past(sp) + 3'h1 ##1 stk[top_idx].pc == $past(cur.pc, 2) + 10'h001)
    else $error("call not stacked");
  wait_op_a: assert property (@(posedge clk) disable iff (!rstn)
    state == ST_WAIT_OP && !op_done && !abort_go && !key_press |=>
    state == ST_WAIT_OP) else $error("left before done");
  inhibit_a: assert property (@(posedge clk) disable iff (!rstn)
    inhibit && exec && cmd.op == OP_OP |->
    !(op_req && (op_code == OPC_AUTOSCALE || op_code == OPC_DATA_MEM)))
    else $error("autoscale not inhibited");
  disrupt_set_a: assert property (@(posedge clk) disable iff (!rstn)
    exec && cmd.op == OP_DISRUPT |=> inhibit)
    else $error("inhibit not set");
  abort_a: assert property (@(posedge clk) disable iff (!rstn)
    key_press |=> state == ST_IDLE && sp == 3'h0)
    else $error("key did not abort");
endmodule // seq_ttl_io

// ### seq_io_fixture.sv
// Purpose: Fixture model on the parallel port of the sequencer
// Assumes: Bench sets switch levels just after a clock edge
// Notes: Undriven output lines read back inverted, never stale
`timescale 1ns/10ps
module seq_io_fixture import seq_io_pkg::*;
(
  // Switch levels from the bench
  input wire logic [NIN-1:0] sw,
  // Port lines
  input wire logic [NOUT-1:0] par_out,
  input wire logic par_out_en,
  output logic [NIN-1:0] par_in,
  output logic [NOUT-1:0] seen
);
  assign par_in = sw;
  // Lines read true while driven, inverted while released
  assign seen = par_out_en ? par_out : ~par_out;
endmodule // seq_io_fixture

// ### seq_ttl_io_tb.sv
// Purpose: Self-checking bench of the sequencer TTL I/O port
// Assumes: Fixture model on the port, engine stub in the bench
// Notes: Registers reached by single AHB-Lite word transfers
`timescale 1ns/10ps
module seq_ttl_io_tb import seq_io_pkg::*;
;
  logic clk, rstn, hsel, hwrite, kick, local_key;
  logic hreadyout, hresp, par_out_en, rear_ttl, sweep_req, op_req;
  logic sweep_end = 1'b0;
  logic op_done = 1'b0;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [NOUT-1:0] par_out, seen;
  logic [NIN-1:0] par_in, sw;
  logic [11:0] op_code;
  int err_count, tests_run, n_auto;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  seq_ttl_io i_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .par_in(par_in), .par_out(par_out),
    .par_out_en(par_out_en), .local_key(local_key), .rear_ttl(rear_ttl),
    .sweep_end(sweep_end), .sweep_req(sweep_req), .op_req(op_req),
    .op_code(op_code), .op_done(op_done));

  seq_io_fixture i_fix (.sw(sw), .par_out(par_out),
    .par_out_en(par_out_en), .par_in(par_in), .seen(seen));

  // Engine stub: finish ops next cycle, count autoscales
  always @(posedge clk)
  begin
    op_done <= op_req;
    sweep_end <= sweep_req | kick;
    if (op_req && op_code === OPC_AUTOSCALE)
      n_auto <= n_auto + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  function automatic logic [15:0] c(input op_e o, input logic [11:0] a);
    return {o, a};
  endfunction

  task automatic ld(input int s, input logic [15:0] w[6]);
    wr(OFS_LOAD_ADDR, 32'(s) << LOAD_SLOT_LSB);
    foreach (w[i])
      wr(OFS_LOAD_DATA, {16'h0, w[i]});
  endtask

  task automatic run(input int s, input logic g);
    logic [31:0] q;
    int n;
    wr(OFS_CTRL, 32'(g) | (32'(s) << CTRL_SLOT_LSB));
    wr(OFS_CTRL, 32'(g) | 32'h4 | (32'(s) << CTRL_SLOT_LSB));
    n = 0;
    q = 32'h1;
    while (q[0] === 1'b1 && n < 300)
    begin
      bus(1'b0, OFS_STATUS, 32'h0, q);
      n++;
    end
    chk("run end", 32'h0, {31'h0, q[0]}); // run completes
  endtask

  task automatic t_port();
    logic [31:0] q;
    ld(0, '{c(OP_OUT_ALL, 12'ha5), c(OP_SET_BIT, 12'h6),
      c(OP_CLR_BIT, 12'h0), 0, 0, 0});
    run(0, 1'b1);
    chk("lines", 32'he4, {24'h0, seen}); // bit edits
    chk("out en", 32'h1, {31'h0, par_out_en}); // gpio drives
    ld(1, '{c(OP_OUT_ALL, 12'h5a), 0, 0, 0, 0, 0});
    run(1, 1'b0);
    chk("copy mode", 32'he4, {24'h0, par_out}); // copy ignores
    chk("out en off", 32'h0, {31'h0, par_out_en}); // released
    bus(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 32'h0, q);
    chk("okay", 32'h0, {31'h0, hresp});
    $display("port test done");
  endtask

  task automatic t_branch();
    ld(2, '{c(OP_OUT_ALL, 12'h22), 0, 0, 0, 0, 0});
    ld(1, '{c(OP_SEL_IN, 12'h4), c(OP_BR_HIGH, 12'h2),
      c(OP_OUT_ALL, 12'h11), 0, 0, 0});
    ld(3, '{c(OP_SEL_IN, 12'h4), c(OP_BR_LOW, 12'h2),
      c(OP_OUT_ALL, 12'h33), 0, 0, 0});
    for (int h = 0; h < 2; h++)
    begin
      sw <= h ? 5'h10 : 5'h0f;
      run(1, 1'b1);
      chk("br high", h ? 32'h22 : 32'h11, {24'h0, seen});
      run(3, 1'b1);
      chk("br low", h ? 32'h33 : 32'h22, {24'h0, seen});
    end
    $display("branch test done");
  endtask

  task automatic t_call();
    ld(4, '{c(OP_GOSUB, 12'h2), c(OP_SET_BIT, 12'h0), 0, 0, 0, 0});
    run(4, 1'b1);
    chk("gosub", 32'h23, {24'h0, seen}); // resumes after call
    ld(0, '{c(OP_JUMP, 12'h2), c(OP_SET_BIT, 12'h0), 0, 0, 0, 0});
    run(0, 1'b1);
    chk("jump", 32'h22, {24'h0, seen}); // no return
    $display("call test done");
  endtask

  task automatic t_ttl();
    logic [31:0] idle, act;
    for (int m = 0; m < 4; m++)
    begin
      idle = {31'h0, m == 0 || m == 3};
      act = {31'h0, m == 0 || m == 2};
      ld(0, '{c(OP_TTL_MODE, 12'(m)), 0, 0, 0, 0, 0});
      run(0, 1'b1);
      chk("ttl idle", idle, {31'h0, rear_ttl}); // static level
      kick <= 1'b1;
      @(posedge clk);
      kick <= 1'b0;
      @(posedge clk);
      #1 chk("ttl first", act, {31'h0, rear_ttl}); // pulse start
      repeat (99) @(posedge clk);
      #1 chk("ttl last", act, {31'h0, rear_ttl}); // pulse length
      @(posedge clk);
      #1 chk("ttl after", idle, {31'h0, rear_ttl}); // pulse end
    end
    $display("ttl test done");
  endtask

  task automatic t_inhibit();
    int a;
    a = n_auto;
    ld(5, '{c(OP_DISRUPT, 12'h0), c(OP_OP, OPC_AUTOSCALE), c(OP_SWEEP, 0),
      c(OP_OP, OPC_AUTOSCALE), 0, 0});
    run(5, 1'b1);
    chk("autoscales", 32'h1, 32'(n_auto - a)); // clean sweep
    $display("inhibit test done");
  endtask

  task automatic t_step();
    logic [31:0] q;
    ld(0, '{c(OP_OUT_ALL, 12'h3c), c(OP_OUT_ALL, 12'hc3), 0, 0, 0, 0});
    q = {24'h0, seen};
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CTRL, 32'h7);
    repeat (8) @(posedge clk);
    chk("step hold", q, {24'h0, seen}); // waits for a step
    wr(OFS_CTRL, 32'hb);
    repeat (4) @(posedge clk);
    chk("step one", 32'h3c, {24'h0, seen}); // one command run
    local_key <= 1'b1;
    repeat (5) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("key abort", 32'h0, {31'h0, q[0]}); // local key stops
    local_key <= 1'b0;
    wr(OFS_CTRL, 32'h7);
    wr(OFS_CTRL, 32'h13);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk("ctrl abort", 32'h0, {31'h0, q[0]}); // abort bit stops
    chk("no step", 32'h3c, {24'h0, seen}); // nothing unstepped
    wr(OFS_CTRL, 32'h1);
    $display("step test done");
  endtask

  task automatic t_loop();
    logic [31:0] q;
    ld(0, '{c(OP_LOOP_SET, 12'h4d2), c(OP_LOOP_DEC, 12'h0),
      c(OP_LOOP_TITLE, 12'h0), 0, 0, 0});
    run(0, 1'b1);
    bus(1'b0, OFS_LOOP_CNT, 32'h0, q);
    chk("loop count", 32'h4d1, q); // counter value
    bus(1'b0, OFS_LOOP_TITLE, 32'h0, q);
    chk("loop title", 32'h01233, q); // five digits
    $display("loop test done");
  endtask

  task automatic t_auto();
    ld(5, '{c(OP_TTL_MODE, 12'h1), 0, 0, 0, 0, 0});
    wr(OFS_TITLE, AUTO_TITLE);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("reset ttl", 32'h1, {31'h0, rear_ttl}); // resets high
    rstn <= 1'b1;
    repeat (10) @(posedge clk);
    chk("autostart", 32'h0, {31'h0, rear_ttl}); // slot five runs
    $display("auto test done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_count++;
    test_done();
  end

  initial
  begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sw = 5'h0;
    local_key = 1'b0;
    kick = 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wr(OFS_CTRL, 32'h1 << CTRL_CLR);
    t_port();
    t_branch();
    t_call();
    t_ttl();
    t_inhibit();
    t_step();
    t_loop();
    t_auto();
    test_done();
  end
endmodule // seq_ttl_io_tb
